// File: rtl/twb_pkg.sv
// Purpose: constants, types and register map of the two-wire bus controller
// Assumes: 10 MHz system clock, classic Wishbone register port, byte-wide DMA port
// Notes: all timing counts derive from the clock rate below
// How it works
// R1 - write task: start condition, address, then direction bit 0.
// R2 - slave acknowledges after direction bit; low is ack, high is nack.
// R3 - after address ack, write fetches bytes from transmit pointer and sends them.
// R4 - suspend finishes the current byte, holds clock low, raises paused event.
// R5 - continue releases the held clock and carries on where it paused.
// R6 - final transmit byte event fires as the last buffer byte begins.
// R7 - controller should stop during the final byte; linking final event to halt works.
// R8 - never ends a transfer alone; holds the bus until a halt task.
// R9 - halt is ignored while suspended; continue first, then halt.
// R10 - read task: start condition, address, then direction bit 1.
// R11 - slave shifts read data on our clock; bytes stored from receive pointer.
// R12 - acknowledge every received byte but the last, which gets nack.
// R13 - final receive event when ready for last byte, after prior ack or address ack.
// R14 - controller must halt before the closing nack; linking final event works.
// R15 - a start task pending at a byte boundary gives a repeated start.
// R16 - software waits for halted event before clearing enable.
// R17 - pin selections act only while enabled; otherwise pins are released.
// R18 - software changes pin selections only while disabled.
// R19 - pins are inputs with open-drain drive before enabling; one driver each.
// R20 - byte counters report bytes moved in the latest transaction.
// R21 - address after every start or repeated start comes from the address register.
// R22 - every sampled nack from the slave raises the fault event.
// R23 - halted event once fully stopped after a halt task.
// R24 - wait for the clock line to really rise, tolerating slave stretching.
// R25 - bus rate chosen among 100, 250 and 400 kbit/s.
// R26 - halt drives a stop condition, data rising with clock high, then releases.
// R27 - begun events once pointer and limit are latched, allowing reload.
package twb_pkg;
  localparam int CLK_KHZ = 10000;
  localparam int KBPS_SLOW = 100;
  localparam int KBPS_MID = 250;
  localparam int KBPS_FAST = 400;
  // half bit periods, rounded up so the bus never runs above the chosen rate
  localparam logic [5:0] HALF_SLOW = 6'((CLK_KHZ + 2 * KBPS_SLOW - 1) / (2 * KBPS_SLOW));
  localparam logic [5:0] HALF_MID = 6'((CLK_KHZ + 2 * KBPS_MID - 1) / (2 * KBPS_MID));
  localparam logic [5:0] HALF_FAST = 6'((CLK_KHZ + 2 * KBPS_FAST - 1) / (2 * KBPS_FAST));
  localparam logic [1:0] RATE_MID = 2'h1;
  localparam logic [1:0] RATE_FAST = 2'h2;
  localparam logic [3:0] ENABLE_ON = 4'h6;
  localparam logic [11:0] OFF_START_RX = 12'h000;
  localparam logic [11:0] OFF_START_TX = 12'h008;
  localparam logic [11:0] OFF_HALT = 12'h014;
  localparam logic [11:0] OFF_PAUSE = 12'h01C;
  localparam logic [11:0] OFF_CONTINUE = 12'h020;
  localparam logic [11:0] OFF_EV_HALTED = 12'h104;
  localparam logic [11:0] OFF_EV_FAULT = 12'h124;
  localparam logic [11:0] OFF_EV_PAUSED = 12'h148;
  localparam logic [11:0] OFF_EV_RXB = 12'h14C;
  localparam logic [11:0] OFF_EV_TXB = 12'h150;
  localparam logic [11:0] OFF_EV_FRX = 12'h15C;
  localparam logic [11:0] OFF_EV_FTX = 12'h160;
  localparam logic [11:0] OFF_LINKS = 12'h200;
  localparam logic [11:0] OFF_IRQ_EN = 12'h300;
  localparam logic [11:0] OFF_IRQ_SET = 12'h304;
  localparam logic [11:0] OFF_IRQ_CLR = 12'h308;
  localparam logic [11:0] OFF_ERR = 12'h4C4;
  localparam logic [11:0] OFF_ENABLE = 12'h500;
  localparam logic [11:0] OFF_SCL_SEL = 12'h508;
  localparam logic [11:0] OFF_SDA_SEL = 12'h50C;
  localparam logic [11:0] OFF_RATE = 12'h524;
  localparam logic [11:0] OFF_RX_PTR = 12'h534;
  localparam logic [11:0] OFF_RX_LIM = 12'h538;
  localparam logic [11:0] OFF_RX_AMT = 12'h53C;
  localparam logic [11:0] OFF_RX_LIST = 12'h540;
  localparam logic [11:0] OFF_TX_PTR = 12'h544;
  localparam logic [11:0] OFF_TX_LIM = 12'h548;
  localparam logic [11:0] OFF_TX_AMT = 12'h54C;
  localparam logic [11:0] OFF_TX_LIST = 12'h550;
  localparam logic [11:0] OFF_ADDR = 12'h588;
  localparam int LNK_FTX_RX = 0;
  localparam int LNK_FTX_PAUSE = 1;
  localparam int LNK_FTX_HALT = 2;
  localparam int LNK_FRX_TX = 3;
  localparam int LNK_FRX_PAUSE = 4;
  localparam int LNK_FRX_HALT = 5;
  localparam int ERR_ADDR_NACK = 0;
  localparam int ERR_DATA_NACK = 1;
  localparam int CNT_W = 16;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_START = 4'h1, ST_BIT_LO = 4'h3, ST_BIT_HI = 4'h2,
    ST_BOUND = 4'h6, ST_FETCH = 4'h7, ST_STORE = 4'h5, ST_STOP_A = 4'h4,
    ST_STOP_B = 4'hC, ST_STOP_C = 4'hD, ST_RS_A = 4'hF, ST_RS_B = 4'hE
  } twb_state_e;

  typedef enum logic [1:0] {PH_ADDR = 2'h0, PH_TX = 2'h1, PH_RX = 2'h3} twb_phase_e;

  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [7:0] wdata;
  } twb_dma_s;
endpackage : twb_pkg

// File: rtl/twb_bus_controller.sv
// Purpose: single-master two-wire bus controller with DMA buffers and Wishbone registers
// Assumes: DMA memory answers each request with a one-cycle ack on this clock
// Notes: pins are open-drain: out is always low, oe pulls the wire low
//
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/100ps
module twb_bus_controller
  import twb_pkg::*;
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [11:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  output twb_dma_s dma_out,
  input wire logic dma_ack_in,
  input wire logic [7:0] dma_rdata_in,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  output logic [31:0] scl_pin_sel_out,
  output logic [31:0] sda_pin_sel_out,
  output logic pins_claimed_out
);
  typedef struct packed {
    logic scl_meta, scl_sync, sda_meta, sda_sync;
    logic wb_ack;
    logic [31:0] wb_rdata;
    logic p_tx, p_rx, p_stop, p_susp, p_res;
    logic ev_halted, ev_fault, ev_paused, ev_rxb, ev_txb, ev_frx, ev_ftx;
    logic [5:0] links;
    logic [31:0] irq_en;
    logic [1:0] err;
    logic [3:0] en;
    logic claim;
    logic [31:0] scl_sel, sda_sel;
    logic [1:0] rate;
    logic [31:0] rx_ptr, tx_ptr, w_ptr;
    logic [CNT_W-1:0] rx_lim, tx_lim, rx_amt, tx_amt, w_lim, idx;
    logic [1:0] rx_list, tx_list;
    logic [6:0] addr;
    twb_state_e st;
    twb_phase_e ph;
    logic dir, susp, err_flag, pin_lvl;
    logic [8:0] shift;
    logic [3:0] bitcnt;
    logic [5:0] cnt;
    twb_dma_s dma;
    logic scl_oe, sda_oe;
  } twb_regs_s;

  twb_regs_s r;
  twb_regs_s n;
  logic [5:0] half;
  logic [11:0] aw;
  logic [31:0] rd;
  logic [31:0] md;
  logic [31:0] lane;
  logic [1:0] s_err;
  logic wr, trig, en_on, n_en, tdone, launch, from_idle, last, more, nack;
  logic drv_scl, drv_sda;
  logic t_rx, t_tx, t_stop, t_susp, t_res;
  logic s_halt, s_fault, s_paused, s_rxb, s_txb, s_frx, s_ftx;

  always_comb begin
    n = r;
    aw = {wb_adr_in[11:2], 2'b00};
    en_on = (r.en == ENABLE_ON);
    case (r.rate)
      RATE_MID: half = HALF_MID; // R25
      RATE_FAST: half = HALF_FAST; // R25
      default: half = HALF_SLOW; // R25
    endcase
    n.scl_meta = scl_in;
    n.scl_sync = r.scl_meta;
    n.sda_meta = sda_in;
    n.sda_sync = r.sda_meta;
    // read view of the addressed register; also the base for byte-lane merges
    case (aw)
      OFF_EV_HALTED: rd = {31'h0, r.ev_halted};
      OFF_EV_FAULT: rd = {31'h0, r.ev_fault};
      OFF_EV_PAUSED: rd = {31'h0, r.ev_paused};
      OFF_EV_RXB: rd = {31'h0, r.ev_rxb};
      OFF_EV_TXB: rd = {31'h0, r.ev_txb};
      OFF_EV_FRX: rd = {31'h0, r.ev_frx};
      OFF_EV_FTX: rd = {31'h0, r.ev_ftx};
      OFF_LINKS: rd = {26'h0, r.links};
      OFF_IRQ_EN, OFF_IRQ_SET, OFF_IRQ_CLR: rd = r.irq_en;
      OFF_ERR: rd = {30'h0, r.err};
      OFF_ENABLE: rd = {28'h0, r.en};
      OFF_SCL_SEL: rd = r.scl_sel;
      OFF_SDA_SEL: rd = r.sda_sel;
      OFF_RATE: rd = {30'h0, r.rate};
      OFF_RX_PTR: rd = r.rx_ptr;
      OFF_RX_LIM: rd = {16'h0, r.rx_lim};
      OFF_RX_AMT: rd = {16'h0, r.rx_amt};
      OFF_RX_LIST: rd = {30'h0, r.rx_list};
      OFF_TX_PTR: rd = r.tx_ptr;
      OFF_TX_LIM: rd = {16'h0, r.tx_lim};
      OFF_TX_AMT: rd = {16'h0, r.tx_amt};
      OFF_TX_LIST: rd = {30'h0, r.tx_list};
      OFF_ADDR: rd = {25'h0, r.addr};
      default: rd = 32'h0;
    endcase
    lane = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}}, {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
    md = (wb_dat_in & lane) | (rd & ~lane);
    n.wb_ack = wb_cyc_in & wb_stb_in & ~r.wb_ack;
    if (wb_cyc_in & wb_stb_in & ~r.wb_ack) begin
      n.wb_rdata = rd;
    end
    // a write lands on the edge where the master sees ack
    wr = wb_cyc_in & wb_stb_in & wb_we_in & r.wb_ack;
    trig = wr & wb_sel_in[0] & wb_dat_in[0];
    t_rx = trig & (aw == OFF_START_RX);
    t_tx = trig & (aw == OFF_START_TX);
    t_stop = trig & (aw == OFF_HALT);
    t_susp = trig & (aw == OFF_PAUSE);
    t_res = trig & (aw == OFF_CONTINUE);
    {s_halt, s_fault, s_paused, s_rxb, s_txb, s_frx, s_ftx} = 7'h00;
    s_err = 2'h0;
    launch = 1'b0;
    from_idle = 1'b0;
    last = (r.idx == r.w_lim - 16'h0001);
    more = (r.idx < r.w_lim) & ~r.err_flag;
    nack = r.sda_sync;
    tdone = (r.cnt == 6'h00);
    // clock-high phases count only once the wire is seen high
    if (~tdone & (r.scl_sync | ~(r.st inside {ST_BIT_HI, ST_RS_B, ST_STOP_B}))) begin
      n.cnt = r.cnt - 6'h01; // R24
    end
    case (r.st)
      ST_IDLE: begin
        if (r.p_stop) begin
          n.p_stop = 1'b0;
          s_halt = 1'b1;
        end else if ((r.p_tx | r.p_rx) & en_on) begin
          launch = 1'b1;
          from_idle = 1'b1;
        end
      end
      ST_START, ST_BIT_LO, ST_RS_A, ST_STOP_A: begin
        if (tdone) begin
          n.st = (r.st == ST_START) ? ST_BIT_LO : (r.st == ST_BIT_LO) ? ST_BIT_HI
                 : (r.st == ST_RS_A) ? ST_RS_B : ST_STOP_B;
          n.cnt = half - 6'h01;
        end
      end
      ST_BIT_HI: begin
        if (tdone & r.scl_sync) begin // R24
          n.shift = {r.shift[7:0], r.sda_sync}; // R11
          n.cnt = half - 6'h01;
          if (r.bitcnt != 4'h8) begin
            n.bitcnt = r.bitcnt + 4'h1;
            n.st = ST_BIT_LO;
          end else if (r.ph == PH_RX) begin
            n.st = ST_STORE;
            n.dma = '{req: 1'b1, we: 1'b1, addr: r.w_ptr + {16'h0, r.idx},
                      wdata: r.shift[7:0]}; // R11
          end else begin
            n.st = ST_BOUND;
            if (nack) begin // R2
              s_fault = 1'b1; // R22
              n.err_flag = 1'b1;
              s_err[(r.ph == PH_ADDR) ? ERR_ADDR_NACK : ERR_DATA_NACK] = 1'b1;
            end else if (r.ph == PH_ADDR) begin
              n.ph = r.dir ? PH_RX : PH_TX;
            end
            if (r.ph == PH_TX) begin
              n.idx = r.idx + 16'h0001;
              n.tx_amt = r.idx + 16'h0001; // R20
            end
          end
        end
      end
      ST_BOUND: begin // R8
        // clock held low here: waiting is stretching, never a stop
        if (r.p_susp) begin
          n.p_susp = 1'b0;
          n.susp = 1'b1; // R4
          s_paused = 1'b1; // R4
        end else if (r.susp) begin
          if (r.p_res) begin
            n.p_res = 1'b0;
            n.susp = 1'b0; // R5
          end
        end else if (r.p_stop) begin
          n.p_stop = 1'b0;
          n.st = ST_STOP_A; // R26
          n.cnt = half - 6'h01;
        end else if (r.p_tx | r.p_rx) begin
          launch = 1'b1; // R15
        end else if (more & (r.ph == PH_RX)) begin
          n.shift = {8'hFF, last}; // R12
          s_frx = last; // R13
          n.st = ST_BIT_LO;
          n.cnt = half - 6'h01;
          n.bitcnt = 4'h0;
        end else if (more & (r.ph == PH_TX)) begin
          n.st = ST_FETCH; // R3
          n.dma = '{req: 1'b1, we: 1'b0, addr: r.w_ptr + {16'h0, r.idx}, wdata: 8'h00};
        end
      end
      ST_FETCH: begin
        if (dma_ack_in) begin
          n.dma.req = 1'b0;
          n.shift = {dma_rdata_in, 1'b1}; // R3
          s_ftx = last; // R6
          n.st = ST_BIT_LO;
          n.cnt = half - 6'h01;
          n.bitcnt = 4'h0;
        end
      end
      ST_STORE: begin
        if (dma_ack_in) begin
          n.dma.req = 1'b0;
          n.idx = r.idx + 16'h0001;
          n.rx_amt = r.idx + 16'h0001; // R20
          n.st = ST_BOUND;
        end
      end
      ST_RS_B, ST_STOP_B: begin
        if (tdone & r.scl_sync) begin // R24
          n.st = (r.st == ST_RS_B) ? ST_START : ST_STOP_C; // R26
          n.cnt = half - 6'h01;
        end
      end
      ST_STOP_C: begin
        if (tdone) begin
          n.st = ST_IDLE;
          s_halt = 1'b1; // R23
        end
      end
      default: n.st = ST_IDLE;
    endcase
    if (launch) begin
      // write wins if both start tasks are pending
      n.dir = ~r.p_tx; // R1 R10
      n.p_tx = 1'b0;
      n.p_rx = r.p_rx & r.p_tx;
      n.w_ptr = r.p_tx ? r.tx_ptr : r.rx_ptr; // R27
      n.w_lim = r.p_tx ? r.tx_lim : r.rx_lim; // R27
      n.idx = 16'h0000;
      n.bitcnt = 4'h0;
      n.tx_amt = r.p_tx ? 16'h0000 : r.tx_amt; // R20
      n.rx_amt = r.p_tx ? r.rx_amt : 16'h0000; // R20
      s_txb = r.p_tx; // R27
      s_rxb = ~r.p_tx; // R27
      n.shift = {r.addr, ~r.p_tx, 1'b1}; // R21
      n.ph = PH_ADDR;
      n.err_flag = 1'b0;
      n.st = from_idle ? ST_START : ST_RS_A; // R15
      n.cnt = half - 6'h01;
    end
    if (wr) begin
      case (aw)
        OFF_EV_HALTED: n.ev_halted = md[0];
        OFF_EV_FAULT: n.ev_fault = md[0];
        OFF_EV_PAUSED: n.ev_paused = md[0];
        OFF_EV_RXB: n.ev_rxb = md[0];
        OFF_EV_TXB: n.ev_txb = md[0];
        OFF_EV_FRX: n.ev_frx = md[0];
        OFF_EV_FTX: n.ev_ftx = md[0];
        OFF_LINKS: n.links = md[5:0];
        OFF_IRQ_EN: n.irq_en = md;
        OFF_IRQ_SET: n.irq_en = r.irq_en | md;
        OFF_IRQ_CLR: n.irq_en = r.irq_en & ~md;
        OFF_ERR: n.err = r.err & ~md[1:0];
        OFF_ENABLE: n.en = md[3:0];
        OFF_SCL_SEL: n.scl_sel = md;
        OFF_SDA_SEL: n.sda_sel = md;
        OFF_RATE: n.rate = md[1:0];
        OFF_RX_PTR: n.rx_ptr = md;
        OFF_RX_LIM: n.rx_lim = md[15:0];
        OFF_RX_LIST: n.rx_list = md[1:0];
        OFF_TX_PTR: n.tx_ptr = md;
        OFF_TX_LIM: n.tx_lim = md[15:0];
        OFF_TX_LIST: n.tx_list = md[1:0];
        OFF_ADDR: n.addr = md[6:0];
        default: n.en = n.en;
      endcase
    end
    // hardware sets come last so they win over a clear in the same cycle
    n.err = n.err | s_err; // R22
    n.ev_halted = n.ev_halted | s_halt;
    n.ev_fault = n.ev_fault | s_fault;
    n.ev_paused = n.ev_paused | s_paused;
    n.ev_rxb = n.ev_rxb | s_rxb;
    n.ev_txb = n.ev_txb | s_txb;
    n.ev_frx = n.ev_frx | s_frx;
    n.ev_ftx = n.ev_ftx | s_ftx;
    n.p_rx = n.p_rx | t_rx | (s_ftx & r.links[LNK_FTX_RX]);
    n.p_tx = n.p_tx | t_tx | (s_frx & r.links[LNK_FRX_TX]);
    n.p_susp = n.p_susp | t_susp | (s_ftx & r.links[LNK_FTX_PAUSE])
               | (s_frx & r.links[LNK_FRX_PAUSE]);
    n.p_res = n.p_res | (t_res & r.susp);
    // a halt that meets a suspended bus is dropped, not queued
    n.p_stop = n.p_stop | (~r.susp & ~n.susp & (t_stop // R9
               | (s_ftx & r.links[LNK_FTX_HALT]) // R7
               | (s_frx & r.links[LNK_FRX_HALT]))); // R14
    n_en = (n.en == ENABLE_ON);
    if (~n_en) begin
      n.st = ST_IDLE;
      {n.p_tx, n.p_rx, n.p_stop, n.p_susp, n.p_res, n.susp} = 6'h00;
      n.dma.req = 1'b0;
    end
    drv_scl = 1'b0;
    drv_sda = r.sda_oe;
    case (n.st)
      ST_START, ST_STOP_B: drv_sda = 1'b1;
      ST_BIT_LO: begin
        drv_scl = 1'b1;
        // data moves one cycle after the clock is low, never with it
        drv_sda = (r.st == ST_BIT_LO) ? ~n.shift[8] : r.sda_oe;
      end
      ST_BIT_HI: drv_sda = ~n.shift[8];
      ST_BOUND, ST_FETCH, ST_STORE: drv_scl = 1'b1; // R4
      ST_RS_A: begin
        drv_scl = 1'b1;
        drv_sda = 1'b0;
      end
      ST_STOP_A: begin
        drv_scl = 1'b1;
        drv_sda = 1'b1;
      end
      default: drv_sda = 1'b0;
    endcase
    n.claim = n_en; // R17
    n.scl_oe = drv_scl & n_en; // R17
    n.sda_oe = drv_sda & n_en; // R17
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign wb_dat_out = r.wb_rdata;
  assign wb_ack_out = r.wb_ack;
  assign dma_out = r.dma;
  assign scl_out = r.pin_lvl;
  assign sda_out = r.pin_lvl;
  assign scl_oe_out = r.scl_oe;
  assign sda_oe_out = r.sda_oe;
  assign scl_pin_sel_out = r.scl_sel;
  assign sda_pin_sel_out = r.sda_sel;
  assign pins_claimed_out = r.claim;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  a_dir_write: assert property ((r.st == ST_START) && (r.ph == PH_ADDR) |-> // R1
    (r.shift[1] == r.dir) && (r.shift[8:2] == r.addr || $past(r.st) != ST_IDLE))
    else $error("direction bit wrong after start");
  a_start_lines: assert property ((r.st == ST_START) && r.claim |-> // R10
    sda_oe_out && !scl_oe_out) else $error("start condition lines wrong");
  a_nack_fault: assert property ((r.st == ST_BIT_HI) && (r.ph != PH_RX) && (r.bitcnt == 4'h8)
    && (r.cnt == 6'h00) && r.scl_sync && r.sda_sync |=> r.ev_fault) // R22
    else $error("nack did not raise fault");
  a_rx_ack_bit: assert property ((r.st == ST_BIT_HI) && (r.ph == PH_RX) && (r.bitcnt == 4'h8)
    && r.claim |-> sda_oe_out == (r.idx != r.w_lim - 16'h0001)) // R12
    else $error("receive ack bit wrong");
  a_pause_hold: assert property (r.susp && r.claim |-> // R4
    scl_oe_out ##1 (scl_oe_out || !r.claim)) else $error("clock not held while suspended");
  a_no_halt_paused: assert property (r.susp |=> r.st != ST_STOP_A) // R9
    else $error("halt taken while suspended");
  a_final_tx: assert property ((r.st == ST_FETCH) && dma_ack_in
    && (r.idx == r.w_lim - 16'h0001) |=> r.ev_ftx && (r.st == ST_BIT_LO)) // R6
    else $error("final transmit event missing");
  a_halted_ev: assert property ((r.st == ST_STOP_C) ##1 (r.st == ST_IDLE) |-> r.ev_halted) // R23
    else $error("halted event missing after stop");
  a_stretch_wait: assert property ((r.st == ST_BIT_HI) && !r.scl_sync |=> // R24
    (r.st == ST_BIT_HI) || !r.claim) else $error("bit ended with clock held low");
  a_pins_off: assert property (!r.claim |-> !scl_oe_out && !sda_oe_out) // R17
    else $error("pin driven while disabled");
  a_wb_ack: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out ##1 !wb_ack_out)
    else $error("bus ack not a single cycle");

  c_write_done: cover property ((r.st == ST_BOUND) && (r.ph == PH_TX) && !more ##[1:400]
    (r.st == ST_STOP_A));
  c_read_done: cover property ((r.st == ST_STORE) && (r.ph == PH_RX) && last);
  c_paused: cover property ($rose(r.susp) ##[1:1000] $fell(r.susp));
  c_restart: cover property ((r.st == ST_RS_B) ##[1:200] (r.st == ST_START));
endmodule : twb_bus_controller

// File: dv/twb_slave_model.sv
// Purpose: behavioural two-wire slave at the far side of the bus
// Assumes: the bench resolves wire levels; a released line reads high
// Notes: read bytes start at C3 and step by 11; the clock is stretched once in every byte
`timescale 1ns/100ps
module twb_slave_model (
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe_out,
  output logic scl_hold_out
);
  logic [7:0] sh, tx, got[$];
  logic [1:0] mack;
  logic rd, first, act;
  int cnt, starts;
  initial begin
    sda_oe_out = 0;
    scl_hold_out = 0;
    act = 0;
    starts = 0;
  end
  always @(negedge sda_in) if (scl_in) begin
    act = 1;
    first = 1;
    cnt = 0;
    starts++;
    tx = 8'hC3;
  end
  always @(posedge sda_in) if (scl_in) act = 0;
  always @(posedge scl_in) if (act) begin
    if (cnt < 8) sh = {sh[6:0], sda_in};
    if (cnt == 7) got.push_back(sh);
    if (cnt == 8 && rd && !first) begin
      mack = {mack[0], sda_in};
      tx = tx + 8'h11;
      // after a nack the line must be free for the stop
      if (sda_in) act = 0;
    end
    cnt++;
  end
  always @(negedge scl_in) begin
    if (act) begin
      if (cnt == 9) begin
        cnt = 0;
        first = 0;
      end
      if (cnt == 8 && first) rd = sh[0];
      if (cnt == 8) sda_oe_out = first ? sh[7:1] == 7'h2A : !rd;
      else sda_oe_out = rd && !first && !tx[7 - cnt];
    end else sda_oe_out = 0;
    // stretch mid-byte so the master has to wait for the wire
    if (act && cnt == 4) begin
      scl_hold_out = 1;
      #2000 scl_hold_out = 0;
    end
  end
endmodule : twb_slave_model

// File: dv/tb.sv
// Purpose: self-checking bench of the two-wire bus controller
// Assumes: memory answers each DMA request one cycle later
// Notes: the fast rate keeps transfers short
`timescale 1ns/100ps
module tb;
  import twb_pkg::*;
  logic clk_in = 0, sys_rst_in = 1, cyc = 0, stb = 0, we = 0, dack = 0, ack, claimed;
  logic [11:0] adr = 0;
  logic [31:0] wd = 0, rd, rdat, ssel, dsel;
  logic [7:0] mem [256], drd = 0;
  logic scl_oe, sda_oe, s_oe, s_hold, scl_o, sda_o;
  logic [11:0] evs [7] = '{OFF_EV_HALTED, OFF_EV_FAULT, OFF_EV_PAUSED, OFF_EV_RXB,
    OFF_EV_TXB, OFF_EV_FRX, OFF_EV_FTX};
  twb_dma_s dma;
  wire scl = !(scl_oe || s_hold);
  wire sda = !(sda_oe || s_oe);
  int miscompares = 0, total_checks = 0;
  twb_bus_controller i_twb_bus_controller (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF),
    .wb_dat_in(wd), .wb_dat_out(rdat), .wb_ack_out(ack), .dma_out(dma),
    .dma_ack_in(dack), .dma_rdata_in(drd), .scl_in(scl), .scl_out(scl_o),
    .scl_oe_out(scl_oe), .sda_in(sda), .sda_out(sda_o), .sda_oe_out(sda_oe),
    .scl_pin_sel_out(ssel), .sda_pin_sel_out(dsel), .pins_claimed_out(claimed));
  twb_slave_model i_slave (.scl_in(scl), .sda_in(sda), .sda_oe_out(s_oe),
    .scl_hold_out(s_hold));
  initial forever #50 clk_in = !clk_in;
  always @(posedge clk_in) begin
    dack <= dma.req && !dack;
    drd <= mem[dma.addr[7:0]];
    if (dma.req && !dack && dma.we) mem[dma.addr[7:0]] <= dma.wdata;
  end
  task automatic wb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk_in);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = rdat;
    cyc <= 0;
    stb <= 0;
    if (n >= 20) miscompares++;
  endtask : wb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    wb(a, 1'b1, d);
  endtask : wr
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    wb(a, 1'b0, 0);
    chk(rd, e);
  endtask : rchk
  task automatic wait_ev(input logic [11:0] a);
    int n;
    n = 0;
    do begin
      wb(a, 1'b0, 0);
      n++;
    end while (rd[0] !== 1'b1 && n < 1500);
    chk(rd, 1);
  endtask : wait_ev
  task automatic clr();
    foreach (evs[i]) wr(evs[i], 0);
    i_slave.got.delete();
  endtask : clr
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  initial begin
    repeat (90000) @(posedge clk_in);
    miscompares++;
    close_out();
  end
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i * 7 + 1);
    repeat (8) @(posedge clk_in);
    sys_rst_in <= 0;
    rchk(OFF_LINKS, 0);
    wr(12'h7F0, 32'h5A);
    rchk(12'h7F0, 0);
    wr(OFF_SCL_SEL, 5);
    repeat (2) @(posedge clk_in);
    chk(ssel, 5);
    chk(claimed, 0);
    wr(OFF_ADDR, 32'h2A);
    wr(OFF_RATE, 32'(RATE_FAST));
    wr(OFF_TX_PTR, 32'h10);
    wr(OFF_TX_LIM, 3);
    wr(OFF_RX_PTR, 32'h80);
    wr(OFF_RX_LIM, 2);
    wr(OFF_ENABLE, 32'(ENABLE_ON));
    wr(OFF_LINKS, 32'h4);
    chk(claimed, 1);
    wr(OFF_START_TX, 1);
    wait_ev(OFF_EV_HALTED);
    chk(i_slave.got[0], 8'h54);
    for (int i = 0; i < 3; i++) chk(i_slave.got[i + 1], mem[16 + i]);
    rchk(OFF_EV_TXB, 1);
    rchk(OFF_EV_FTX, 1);
    rchk(OFF_TX_AMT, 3);
    $display("write test done");
    clr();
    wr(OFF_LINKS, 32'h20);
    wr(OFF_START_RX, 1);
    wait_ev(OFF_EV_HALTED);
    chk(i_slave.got[0], 8'h55);
    chk({mem[8'h80], mem[8'h81]}, 16'hC3D4);
    chk(i_slave.mack, 2'b01);
    rchk(OFF_EV_FRX, 1);
    rchk(OFF_RX_AMT, 2);
    $display("read test done");
    clr();
    wr(OFF_LINKS, 0);
    wr(OFF_TX_LIM, 2);
    wr(OFF_START_TX, 1);
    wr(OFF_PAUSE, 1);
    wait_ev(OFF_EV_PAUSED);
    repeat (100) @(posedge clk_in);
    chk(scl, 0);
    wr(OFF_HALT, 1);
    wr(OFF_CONTINUE, 1);
    repeat (1500) @(posedge clk_in);
    rchk(OFF_EV_HALTED, 0);
    chk(32'(i_slave.got.size()), 3);
    wr(OFF_HALT, 1);
    wait_ev(OFF_EV_HALTED);
    $display("suspend test done");
    clr();
    wr(OFF_ADDR, 32'h15);
    wr(OFF_START_TX, 1);
    wait_ev(OFF_EV_FAULT);
    rchk(OFF_ERR, 1);
    rchk(OFF_EV_HALTED, 0);
    wr(OFF_HALT, 1);
    wait_ev(OFF_EV_HALTED);
    $display("nack test done");
    clr();
    wr(OFF_ADDR, 32'h2A);
    wr(OFF_TX_LIM, 1);
    wr(OFF_RX_LIM, 1);
    wr(OFF_RX_PTR, 32'h90);
    wr(OFF_LINKS, 32'h21);
    wr(OFF_RATE, 32'(RATE_MID));
    i_slave.starts = 0;
    wr(OFF_START_TX, 1);
    wait_ev(OFF_EV_HALTED);
    chk(32'(i_slave.starts), 2);
    chk(mem[8'h90], 8'hC3);
    rchk(OFF_EV_FRX, 1);
    wr(OFF_ENABLE, 0);
    repeat (2) @(posedge clk_in);
    chk({claimed, scl_oe, sda_oe}, 0);
    $display("repeated start test done");
    close_out();
  end
endmodule : tb
